// ===== design/arap_port.v
// Purpose: asynchronous 8-bit host register access port
// Assumes: host strobes asynchronous, sampled into mclk at 200 MHz
// Notes: open-drain and data pins split into in/out/enable (oe low = drive)
`include "arap_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - drive data while read and select low
// - write data on rising write strobe edge
// - eight-bit address selects one register
// - address bit seven selects test registers
// - low address latch transparent while ale high
// - reset input low resets on the next mclk edge, unsynchronised
// - irq pulled low on unmasked active source
// - acknowledge access releases irq output
// - reset out low on reset, force, activate
// - deactivate code releases unless force set
module arap_port #(
   parameter NUM_SRC = 8
) (
   input wire mclk,
   input wire rst,
   input wire reset_in_n,
   input wire chip_select_n,
   input wire read_strobe_n,
   input wire write_strobe_n,
   input wire address_latch_enable,
   input wire [`ARAP_ADDR_W-1:0] addr,
   input wire [`ARAP_DATA_W-1:0] data_in,
   output reg [`ARAP_DATA_W-1:0] data_out,
   output reg data_oe_n,
   input wire [NUM_SRC-1:0] irq_src,
   input wire remote_rst_activate,
   input wire remote_rst_deactivate,
   output reg irq_out_n,
   output reg irq_oe_n,
   output reg reset_out_n,
   output reg reset_out_oe_n
);
   // synchronised strobes: cs, rd, wr, ale
   wire [3:0] strb_s;
   // reset input synchronised for release
   wire [0:0] rin_s;
   reg wr_prev_r; // previous synchronised write level
   reg rd_prev_r; // read active in previous cycle
   reg [`ARAP_LATCH_HI:0] alat_r; // low address latch
   reg [`ARAP_DATA_W-1:0] cfg_r; // master configuration
   reg [`ARAP_DATA_W-1:0] int_en_r; // interrupt enables
   reg [`ARAP_DATA_W-1:0] int_st_r; // sticky interrupt status
   reg [`ARAP_DATA_W-1:0] int_st_nxt;
   reg [`ARAP_DATA_W-1:0] scratch_r; // general scratch register
   reg [`ARAP_DATA_W-1:0] test_r; // test control register
   reg remote_rst_r; // remote reset held by link code
   reg [`ARAP_DATA_W-1:0] rd_mux; // read data from decode
   wire [`ARAP_ADDR_W-1:0] eff_addr; // decoded register address
   wire cs_a; // select active
   wire rd_a; // read active
   wire wr_rise; // write strobe rising edge
   wire wr_commit; // write committed this cycle
   wire ack_read; // status read acknowledges interrupts
   wire irq_any; // any unmasked active source
   wire int_rst; // combined internal reset
   wire force_rst; // configuration force bit

   // strobe synchroniser, all idle high except ale
   arap_sync #(
      .WIDTH(4),
      .INIT(4'hE)
   ) u_strb (
      .mclk(mclk),
      .rst(rst),
      .d({chip_select_n, read_strobe_n, write_strobe_n, address_latch_enable}),
      .q(strb_s)
   );

   // reset input synchroniser for clean release
   arap_sync #(
      .WIDTH(1),
      .INIT(1'b0)
   ) u_rin (
      .mclk(mclk),
      .rst(rst),
      .d(reset_in_n),
      .q(rin_s)
   );

   // reset_in_n acts at once, release seen through synchroniser
   assign int_rst = rst | ~reset_in_n | ~rin_s[0];
   assign cs_a = ~strb_s[3];
   assign rd_a = cs_a & ~strb_s[2];
   assign wr_rise = strb_s[1] & ~wr_prev_r;
   assign wr_commit = wr_rise & cs_a;
   // top bits pass straight, low six via latch
   assign eff_addr = {addr[`ARAP_TRS_BIT:`ARAP_LATCH_HI+1], alat_r};
   assign force_rst = cfg_r[`ARAP_CFG_RST_FORCE];
   // acknowledge at read end so the byte read stays stable while driven
   assign ack_read = rd_prev_r & ~rd_a & (eff_addr == `ARAP_OFS_INT_STATUS);
   assign irq_any = |(int_st_r & int_en_r);

   // address latch: follows while ale high, holds while low
   always @(posedge mclk) begin
      if (int_rst) begin
         alat_r <= {(`ARAP_LATCH_HI+1){1'b0}};
      end else if (strb_s[0]) begin
         alat_r <= addr[`ARAP_LATCH_HI:0];
      end
   end

   // register read decode
   always @* begin
      case (eff_addr)
         `ARAP_OFS_MASTER_CFG: rd_mux = cfg_r;
         `ARAP_OFS_INT_STATUS: rd_mux = int_st_r;
         `ARAP_OFS_INT_ENABLE: rd_mux = int_en_r;
         `ARAP_OFS_SCRATCH: rd_mux = scratch_r;
         `ARAP_OFS_REMOTE_RST: rd_mux = {7'h00, remote_rst_r};
         `ARAP_OFS_TEST_CTRL: rd_mux = test_r;
         `ARAP_OFS_TEST_ID: rd_mux = `ARAP_TEST_ID_VAL;
         default: rd_mux = `ARAP_UNMAPPED;
      endcase
   end

   // status: new events win over acknowledge clear
   always @* begin
      int_st_nxt = int_st_r;
      if (ack_read) begin
         int_st_nxt = {`ARAP_DATA_W{1'b0}};
      end
      int_st_nxt = int_st_nxt | irq_src[`ARAP_DATA_W-1:0];
   end

   // register writes and status update
   always @(posedge mclk) begin
      if (int_rst) begin
         wr_prev_r <= 1'b1;
         rd_prev_r <= 1'b0;
         cfg_r <= `ARAP_RST_CFG;
         int_en_r <= `ARAP_RST_INT_EN;
         int_st_r <= {`ARAP_DATA_W{1'b0}};
         scratch_r <= `ARAP_RST_SCRATCH;
         test_r <= `ARAP_RST_TEST;
      end else begin
         wr_prev_r <= strb_s[1];
         rd_prev_r <= rd_a;
         int_st_r <= int_st_nxt;
         if (wr_commit) begin
            case (eff_addr)
               `ARAP_OFS_MASTER_CFG: cfg_r <= data_in;
               `ARAP_OFS_INT_ENABLE: int_en_r <= data_in;
               `ARAP_OFS_SCRATCH: scratch_r <= data_in;
               `ARAP_OFS_TEST_CTRL: test_r <= data_in;
               default: ;
            endcase
         end
      end
   end

   // remote reset state from validated link codes
   always @(posedge mclk) begin
      if (int_rst) begin
         remote_rst_r <= 1'b0;
      end else if (remote_rst_activate) begin
         remote_rst_r <= 1'b1;
      end else if (remote_rst_deactivate) begin
         remote_rst_r <= 1'b0;
      end
   end

   // pin outputs, all registered
   always @(posedge mclk) begin
      if (int_rst) begin
         data_out <= {`ARAP_DATA_W{1'b0}};
         data_oe_n <= 1'b1;
         irq_out_n <= 1'b0;
         irq_oe_n <= 1'b1;
         reset_out_n <= 1'b0;
         reset_out_oe_n <= 1'b0;
      end else begin
         // drive only while read and select both low
         data_out <= rd_mux;
         data_oe_n <= ~rd_a;
         irq_out_n <= 1'b0;
         irq_oe_n <= ~(irq_any & ~ack_read);
         reset_out_n <= 1'b0;
         // force keeps line low despite deactivate code
         reset_out_oe_n <= ~(force_rst | remote_rst_r);
      end
   end
endmodule // arap_port
`default_nettype wire

// ===== design/arap_defs.vh
// Purpose: constants for the register access port
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef ARAP_DEFS_VH
`define ARAP_DEFS_VH
// address layout
`define ARAP_ADDR_W 8
`define ARAP_DATA_W 8
`define ARAP_TRS_BIT 7
`define ARAP_LATCH_HI 5
// normal-mode register offsets
`define ARAP_OFS_MASTER_CFG 8'h00
`define ARAP_OFS_INT_STATUS 8'h01
`define ARAP_OFS_INT_ENABLE 8'h02
`define ARAP_OFS_SCRATCH 8'h03
`define ARAP_OFS_REMOTE_RST 8'h04
// test-mode register offsets (address bit 7 set)
`define ARAP_OFS_TEST_CTRL 8'h80
`define ARAP_OFS_TEST_ID 8'h81
// master configuration field positions
`define ARAP_CFG_RST_FORCE 0
// reset values
`define ARAP_RST_CFG 8'h00
`define ARAP_RST_INT_EN 8'h00
`define ARAP_RST_SCRATCH 8'h00
`define ARAP_RST_TEST 8'h00
// identity value, arbitrary
`define ARAP_TEST_ID_VAL 8'h5A
// read data for unmapped addresses
`define ARAP_UNMAPPED 8'h00
// strobe synchroniser depth
`define ARAP_SYNC_STAGES 2
`endif

// ===== design/arap_sync.v
// Purpose: two-stage synchroniser for asynchronous host strobes
// Assumes: mclk domain, synchronous active-high reset
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module arap_sync #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   input wire mclk,
   input wire rst,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_r; // first stage
   reg [WIDTH-1:0] sync_r; // second stage

   // two flops per bit
   always @(posedge mclk) begin
      if (rst) begin
         meta_r <= INIT;
         sync_r <= INIT;
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;
endmodule // arap_sync
`default_nettype wire

// ===== sim/arap_monitor.sv
// Purpose: port checker for the register access port
// Assumes: one mclk domain, oe low means the device drives
// Notes: bound to arap_port below
`timescale 1ns/1ps
`default_nettype none
module arap_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reset_in_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic data_oe_n,
   input wire logic irq_out_n,
   input wire logic irq_oe_n,
   input wire logic reset_out_n,
   input wire logic reset_out_oe_n,
   input wire logic remote_rst_activate
);
   wire rd_act = !chip_select_n && !read_strobe_n; // read cycle selected
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || !reset_in_n);
   a_read_drive: assert property (rd_act [*6] |-> !data_oe_n)
      else $error("data bus not driven during read");
   a_drive_delay: assert property ($fell(data_oe_n) |-> $past(rd_act, 3))
      else $error("data bus driven at wrong time");
   a_idle_release: assert property (!rd_act [*6] |-> data_oe_n)
      else $error("data bus driven while idle");
   a_release_delay: assert property ($rose(data_oe_n) |-> !$past(rd_act, 3))
      else $error("data bus released at wrong time");
   a_irq_level: assert property (!irq_oe_n |-> !irq_out_n)
      else $error("irq drives a high level");
   a_rstout_level: assert property (!reset_out_oe_n |-> !reset_out_n)
      else $error("reset out drives a high level");
   a_activate_pull: assert property (remote_rst_activate |-> ##[1:3] !reset_out_oe_n)
      else $error("activate code did not pull reset out");
   a_reset_in: assert property (disable iff (rst) !reset_in_n |=> !reset_out_oe_n && data_oe_n)
      else $error("reset input not obeyed");
   c_read: cover property (rd_act ##3 !data_oe_n);
   c_irq: cover property ($fell(irq_oe_n));
   c_rstout: cover property ($fell(reset_out_oe_n));
endmodule // arap_monitor
bind arap_port arap_monitor i_mon (.mclk, .rst, .reset_in_n, .chip_select_n, .read_strobe_n,
   .data_oe_n, .irq_out_n, .irq_oe_n, .reset_out_n, .reset_out_oe_n, .remote_rst_activate);
`default_nettype wire

// ===== sim/arap_host.sv
// Purpose: host processor model driving the strobes
// Assumes: read and write strobes held 4 cycles low, then at least 8 cycles high
// Notes: released write data shows its inverse
`timescale 1ns/1ps
`default_nettype none
module arap_host (
   input wire logic mclk,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   output logic chip_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic address_latch_enable,
   output logic [7:0] addr,
   output logic [7:0] data_in
);
   initial begin
      {chip_select_n, read_strobe_n, write_strobe_n, address_latch_enable} = 4'hF;
      addr = 8'h00;
      data_in = 8'hFF;
   end
   // one access, w high for a write
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge mclk);
      #1;
      addr = a;
      data_in = d;
      chip_select_n = 1'b0;
      read_strobe_n = w;
      write_strobe_n = !w;
      repeat (4) @(posedge mclk);
      q = data_oe_n ? 8'hxx : data_out;
      #1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chip_select_n = 1'b1;
      data_in = ~d;
      repeat (4) @(posedge mclk);
      #1;
   endtask
endmodule // arap_host
`default_nettype wire

// ===== sim/arap_port_tb.sv
// Purpose: self-checking bench for arap_port
// Assumes: host model owns the strobes
// Notes: inputs change 1 ns after mclk rises
`include "arap_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module arap_port_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic reset_in_n = 1'b1;
   logic [7:0] irq_src = 8'h00;
   logic remote_rst_activate = 1'b0;
   logic remote_rst_deactivate = 1'b0;
   wire chip_select_n, read_strobe_n, write_strobe_n, address_latch_enable, data_oe_n;
   wire irq_out_n, irq_oe_n, reset_out_n, reset_out_oe_n;
   wire [7:0] addr, data_in, data_out;
   int n_mismatch = 0;
   int compares = 0;
   logic [7:0] q;
   always #2.5 mclk = ~mclk;
   arap_port i_arap_port (.mclk, .rst, .reset_in_n, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .address_latch_enable, .addr, .data_in, .data_out, .data_oe_n,
      .irq_src, .remote_rst_activate, .remote_rst_deactivate, .irq_out_n, .irq_oe_n,
      .reset_out_n, .reset_out_oe_n);
   arap_host i_arap_host (.mclk, .data_out, .data_oe_n, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .address_latch_enable, .addr, .data_in);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test;
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task t_regs; // scratch, test space, unmapped, latched address
      i_arap_host.acc(1, 8'h03, 8'hA5, q);
      i_arap_host.acc(0, 8'h03, 8'h00, q);
      chk(q, 8'hA5);
      i_arap_host.acc(0, 8'h81, 8'h00, q);
      chk(q, `ARAP_TEST_ID_VAL);
      i_arap_host.acc(0, 8'h83, 8'h00, q);
      chk(q, 8'h00);
      cyc(1);
      i_arap_host.addr = 8'h03;
      cyc(2);
      i_arap_host.address_latch_enable = 1'b0;
      cyc(2);
      i_arap_host.acc(0, 8'h00, 8'h00, q);
      chk(q, 8'hA5);
      i_arap_host.address_latch_enable = 1'b1;
   endtask
   task t_remote; // activate, deactivate, forced hold
      remote_rst_activate = 1'b1;
      cyc(1);
      remote_rst_activate = 1'b0;
      cyc(3);
      chk({7'h0, reset_out_oe_n}, 8'h00);
      remote_rst_deactivate = 1'b1;
      cyc(1);
      remote_rst_deactivate = 1'b0;
      cyc(3);
      chk({7'h0, reset_out_oe_n}, 8'h01);
      i_arap_host.acc(1, 8'h00, 8'h01, q);
      remote_rst_deactivate = 1'b1;
      cyc(1);
      remote_rst_deactivate = 1'b0;
      cyc(3);
      chk({7'h0, reset_out_oe_n}, 8'h00);
      i_arap_host.acc(1, 8'h00, 8'h00, q);
   endtask
   task t_irq; // masked source, unmasked source, acknowledge
      i_arap_host.acc(1, 8'h02, 8'h01, q);
      irq_src = 8'h02;
      cyc(4);
      chk({7'h0, irq_oe_n}, 8'h01);
      irq_src = 8'h01;
      cyc(1);
      irq_src = 8'h00;
      cyc(3);
      chk({7'h0, irq_oe_n}, 8'h00);
      i_arap_host.acc(0, 8'h01, 8'h00, q);
      chk(q, 8'h03);
      chk({7'h0, irq_oe_n}, 8'h01);
   endtask
   task t_rstin; // reset input pulls reset out and clears registers
      reset_in_n = 1'b0;
      cyc(2);
      chk({7'h0, reset_out_oe_n}, 8'h00);
      reset_in_n = 1'b1;
      cyc(4);
      i_arap_host.acc(0, 8'h03, 8'h00, q);
      chk(q, `ARAP_RST_SCRATCH);
   endtask
   initial begin
      cyc(4);
      rst = 1'b0;
      cyc(2);
      t_regs;
      t_remote;
      t_irq;
      t_rstin;
      end_of_test;
   end
   // whole run is about 160 cycles, so 20 us means a hang
   initial begin
      #20000;
      n_mismatch++;
      end_of_test;
   end
endmodule // arap_port_tb
`default_nettype wire
